// [rtl/edc_control.sv]
// Function
// - Result integer over 16 digits: system error
// - Memory result or operand over 8: error
// - Markup or markdown over 8 digits: error
// - Divide by zero, negative root: error
// - 9 to 16 digit arith, percent, square, reciprocal or power results: rough error
// - System error shows zero and error symbol
// - Rough error: upper digits, scaled point
// - Clear keys release a system error
// - Clear keys release rough; entry clear keeps
// - Ninth and later entry digits ignored
// - Memory untouched on any error
// - Memory symbol while memory nonzero
// - Off beats all-clear when both pressed
// - Press accepted after one to two words
// - Release debounced after eight to nine words
// - Auto power-off about ten minutes idle
// - All-clear resets calculation, keeps memory
// - Floating point, leading zeros blanked
`timescale 1ns/1ps
module edc_control
    import edc_pkg::*;
#(
    parameter int WORD_CYCLES = WORD_CYC,
    parameter int APO_WORDS   = APO_WORD_CNT
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Key matrix pins
    input  wire logic [KEY_N-1:0] key_raw,
    // Datapath result
    input  wire logic             res_valid,
    input  wire edc_kind_t        res_kind,
    input  wire logic [DIG_W-1:0] res_int_digits,
    input  wire logic [DP_W-1:0]  res_dp_pos,
    input  wire logic             res_div_zero,
    input  wire logic             res_sqrt_neg,
    input  wire logic [DIG_W-1:0] mem_operand_digits,
    input  wire logic             mem_store_req,
    input  wire logic             mem_nonzero,
    // Key events
    output logic                  key_accept,
    output logic [KEY_W-1:0]      key_code,
    output logic                  key_held,
    output logic                  digit_accept,
    output logic [ENT_W-1:0]      entry_count,
    // Control
    output logic                  clear_all,
    output logic                  clear_entry,
    output logic                  keep_result,
    output logic                  mem_write,
    output logic                  power_on,
    // Errors and display
    output logic                  sys_error,
    output logic                  rough_error,
    output logic                  err_sym,
    output logic                  mem_sym,
    output logic                  force_zero,
    output logic [DP_W-1:0]       dp_pos,
    output logic                  zero_shift,
    output logic                  lead_blank
);

    localparam int WCW = $clog2(WORD_CYCLES + 1);
    localparam int AW  = $clog2(APO_WORDS + 1);

    function automatic logic [KEY_W:0] key_pick(input logic [KEY_N-1:0] k);
        logic [KEY_W:0] r;
        r = '0;
        for (int i = KEY_N - 1; i >= 0; i--)
            if (k[i])
                r = {1'b1, KEY_W'(i)};
        if (k[KEY_AC])
            r = {1'b1, KEY_AC};
        if (k[KEY_OFF])
            r = {1'b1, KEY_OFF};
        return r;
    endfunction : key_pick

    function automatic logic is_entry(input logic [KEY_W-1:0] c);
        return c <= KEY_D9 || c == KEY_DOT;
    endfunction : is_entry

    edc_state_t       state;
    logic [KEY_N-1:0] key_s1;
    logic [KEY_N-1:0] key_s2;
    logic [KEY_W:0]   picked;
    logic [WCW-1:0]   word_cnt;
    logic             word_tick;
    logic [AW-1:0]    apo_cnt;
    logic             press;
    logic [KEY_W-1:0] db_code;
    logic             res_take;
    logic             rough_kind;
    logic             over8;
    logic             off_now;
    logic             res_sys;
    logic             res_rough;
    logic             res_ok;
    logic             key_pass;
    logic             clr_key;
    logic             apo_expire;

    // Matrix pins are asynchronous to clk
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            key_s1 <= '0;
            key_s2 <= '0;
        end
        else
        begin
            key_s1 <= key_raw;
            key_s2 <= key_s1;
        end
    end

    assign picked = key_pick(key_s2);

    // Display word timebase
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            word_cnt  <= '0;
            word_tick <= 1'b0;
        end
        else
        begin
            word_tick <= word_cnt == WCW'(WORD_CYCLES - 1);
            if (word_cnt == WCW'(WORD_CYCLES - 1))
                word_cnt <= '0;
            else
                word_cnt <= word_cnt + 1'b1;
        end
    end

    edc_debounce u_debounce
    (
        .clk       (clk),
        .resetn    (resetn),
        .word_tick (word_tick),
        .raw_any   (picked[KEY_W]),
        .raw_code  (picked[KEY_W-1:0]),
        .press     (press),
        .held      (key_held),
        .code      (db_code)
    );

    // Result classification
    assign clr_key    = db_code == KEY_AC || db_code == KEY_CE;
    assign apo_expire = state != ST_OFF && word_tick && apo_cnt >= AW'(APO_WORDS - 1);
    assign off_now    = state != ST_OFF && (apo_expire || (press && db_code == KEY_OFF));
    assign res_take   = res_valid && state != ST_OFF && !off_now;
    assign rough_kind = res_kind inside {KIND_ARITH, KIND_PCT, KIND_SQUARE, KIND_RECIP,
                                         KIND_POWER};
    assign over8      = res_int_digits > MAX_DIGITS;
    assign res_sys    = res_take && (res_div_zero || res_sqrt_neg
                        || (over8 && !(rough_kind && res_int_digits <= ROUGH_DIGITS))
                        || (res_kind == KIND_MEMORY && mem_operand_digits > MAX_DIGITS));
    assign res_rough  = res_take && !res_sys && rough_kind && over8;
    assign res_ok     = res_take && !res_sys && !res_rough;

    // While off only the on/clear key passes; errors lock out all but clears and off
    assign key_pass = press && ((state == ST_OFF) ? db_code == KEY_CE
                                : (state == ST_READY || clr_key || db_code == KEY_OFF));

    // Operating state and error flags
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state       <= ST_READY;
            power_on    <= 1'b1;
            sys_error   <= 1'b0;
            rough_error <= 1'b0;
        end
        else
        begin
            case (state)
                ST_OFF:
                begin
                    if (key_pass)
                    begin
                        state    <= ST_READY;
                        power_on <= 1'b1;
                    end
                end
                ST_READY, ST_SYS_ERR, ST_ROUGH_ERR:
                begin
                    if (off_now)
                    begin
                        state       <= ST_OFF;
                        power_on    <= 1'b0;
                        sys_error   <= 1'b0;
                        rough_error <= 1'b0;
                    end
                    // A new error wins over a clear key in the same cycle
                    else if (res_sys)
                    begin
                        state       <= ST_SYS_ERR;
                        sys_error   <= 1'b1;
                        rough_error <= 1'b0;
                    end
                    else if (res_rough)
                    begin
                        state       <= ST_ROUGH_ERR;
                        rough_error <= 1'b1;
                    end
                    else if (key_pass && clr_key)
                    begin
                        state       <= ST_READY;
                        sys_error   <= 1'b0;
                        rough_error <= 1'b0;
                    end
                end
                default:
                    state <= ST_READY;
            endcase
        end
    end

    // Key hand-off and clear strobes
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            key_accept  <= 1'b0;
            key_code    <= '0;
            clear_all   <= 1'b0;
            clear_entry <= 1'b0;
            keep_result <= 1'b0;
        end
        else
        begin
            key_accept  <= key_pass;
            if (key_pass)
                key_code <= db_code;
            clear_all   <= key_pass && (state == ST_OFF || db_code == KEY_AC);
            clear_entry <= key_pass && state != ST_OFF && db_code == KEY_CE;
            keep_result <= key_pass && state == ST_ROUGH_ERR && db_code == KEY_CE;
        end
    end

    // Number entry limit
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            digit_accept <= 1'b0;
            entry_count  <= '0;
        end
        else
        begin
            digit_accept <= 1'b0;
            if (key_pass && state == ST_READY && db_code <= KEY_D9)
            begin
                if (entry_count < MAX_ENTRY)
                begin
                    digit_accept <= 1'b1;
                    entry_count  <= entry_count + 4'h1;
                end
            end
            else if (key_pass && !is_entry(db_code))
                entry_count <= '0;
        end
    end

    // Display flags and memory write gate
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            err_sym    <= 1'b0;
            force_zero <= 1'b0;
            dp_pos     <= DP_NONE;
            zero_shift <= 1'b1;
            lead_blank <= 1'b1;
            mem_sym    <= 1'b0;
            mem_write  <= 1'b0;
        end
        else
        begin
            mem_sym    <= mem_nonzero && state != ST_OFF && !off_now;
            mem_write  <= mem_store_req && state == ST_READY && res_ok == res_valid
                          && !off_now;
            lead_blank <= 1'b1;
            if (off_now || (key_pass && !res_take && (db_code == KEY_AC || state == ST_OFF)))
            begin
                err_sym    <= 1'b0;
                force_zero <= 1'b0;
                dp_pos     <= DP_NONE;
                zero_shift <= 1'b1;
            end
            else if (res_sys)
            begin
                err_sym    <= 1'b1;
                force_zero <= 1'b1;
                dp_pos     <= DP_NONE;
                zero_shift <= 1'b0;
            end
            else if (res_rough)
            begin
                err_sym    <= 1'b1;
                force_zero <= 1'b0;
                dp_pos     <= DP_W'(ROUGH_DIGITS - res_int_digits);
                zero_shift <= 1'b0;
            end
            else if (res_ok)
            begin
                err_sym    <= 1'b0;
                force_zero <= 1'b0;
                dp_pos     <= res_dp_pos;
                zero_shift <= 1'b1;
            end
            else if (key_pass && db_code == KEY_CE)
            begin
                // Entry clear drops the symbol but keeps a rough result on show
                err_sym    <= 1'b0;
                force_zero <= 1'b0;
            end
        end
    end

    // Auto power-off interval, in display words
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            apo_cnt <= '0;
        else if (press || state == ST_OFF)
            apo_cnt <= '0;
        else if (word_tick && apo_cnt < AW'(APO_WORDS - 1))
            apo_cnt <= apo_cnt + 1'b1;
    end

    // Run lengths of the synchronised key level, read only by checks
    int hold_cyc;
    int free_cyc;
    localparam int REL_MIN = (RELEASE_WORDS - 1) * WORD_CYCLES;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hold_cyc <= 0;
            free_cyc <= 0;
        end
        else
        begin
            hold_cyc <= picked[KEY_W] ? hold_cyc + 1 : 0;
            free_cyc <= picked[KEY_W] ? 0 : free_cyc + 1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_apo_due;
        apo_expire && !press;
    endsequence
    sequence s_powered_down;
        !power_on && state == ST_OFF && !sys_error && !rough_error;
    endsequence
    sequence s_ac_taken;
        key_pass && db_code == KEY_AC && !res_sys && !res_rough;
    endsequence

    chk_sys_overflow: assert property (res_take && !off_now && over8 && !rough_kind
        |=> sys_error && state == ST_SYS_ERR) else $error("overflow without system error");
    chk_sys_memop: assert property (res_take && res_kind == KIND_MEMORY
        && mem_operand_digits > MAX_DIGITS |=> sys_error) else $error("memory overflow missed");
    chk_sys_markup: assert property (res_take && res_kind == KIND_MARKUP && over8
        |=> sys_error) else $error("markup overflow missed");
    chk_sys_divzero: assert property (res_take && (res_div_zero || res_sqrt_neg)
        |=> sys_error && !rough_error) else $error("divide or root fault missed");
    chk_rough_range: assert property (res_take && rough_kind && over8
        && res_int_digits <= ROUGH_DIGITS && !res_div_zero && !res_sqrt_neg
        |=> rough_error && !sys_error) else $error("rough error not flagged");
    chk_sys_display: assert property (res_sys |=> force_zero && err_sym
        && dp_pos == DP_NONE) else $error("system error display wrong");
    chk_rough_point: assert property (res_rough |=> err_sym && !zero_shift
        && dp_pos == DP_W'(ROUGH_DIGITS - $past(res_int_digits))) else $error("rough point wrong");
    chk_err_release: assert property (state == ST_SYS_ERR && key_pass && clr_key
        && !res_sys |=> !sys_error ##1 !sys_error) else $error("system error not released");
    chk_ce_keeps: assert property (state == ST_ROUGH_ERR && key_pass && db_code == KEY_CE
        && !res_take |=> keep_result && !rough_error && !clear_all) else $error("CE lost result");
    chk_entry_limit: assert property (entry_count == MAX_ENTRY && press && db_code <= KEY_D9
        |=> !digit_accept && entry_count == MAX_ENTRY) else $error("ninth digit accepted");
    chk_mem_protect: assert property (res_sys || res_rough || state != ST_READY
        |=> !mem_write) else $error("memory written during error");
    chk_mem_symbol: assert property (power_on && !off_now |=> mem_sym == $past(mem_nonzero))
        else $error("memory symbol mismatch");
    chk_off_priority: assert property (key_s2[KEY_OFF] && key_s2[KEY_AC]
        |-> picked == {1'b1, KEY_OFF}) else $error("all-clear beat off");
    chk_press_window: assert property (press |-> hold_cyc >= WORD_CYCLES
        && hold_cyc <= 3 * WORD_CYCLES) else $error("press accepted outside window");
    chk_release_time: assert property ($fell(key_held) |-> free_cyc >= REL_MIN)
        else $error("release debounced too soon");
    chk_apo_off: assert property (s_apo_due |=> s_powered_down)
        else $error("auto power-off missed");
    chk_ac_clear: assert property (s_ac_taken |=> clear_all && !mem_write
        && !sys_error ##1 !clear_all) else $error("all-clear misbehaved");
    chk_dp_float: assert property (res_ok |=> dp_pos == $past(res_dp_pos) && lead_blank
        && zero_shift && !err_sym) else $error("floating point not applied");
    chk_apo_restart: assert property (press |=> apo_cnt == '0)
        else $error("power-off timer not restarted");

endmodule : edc_control

// [rtl/edc_pkg.sv]
package edc_pkg;

    // Clock and display timing
    localparam int CLK_HZ        = 50_000_000;
    localparam int WORD_TIME_US  = 3300;
    localparam int WORD_CYC      = CLK_HZ / 1_000_000 * WORD_TIME_US;
    localparam int PRESS_WORDS   = 2;
    localparam int RELEASE_WORDS = 9;

    // Auto power-off, chosen inside the 9 to 11 minute window
    localparam int APO_TIME_MIN  = 10;
    localparam int APO_WORD_CNT  = APO_TIME_MIN * 60 * 1_000_000 / WORD_TIME_US;

    // Key matrix, one bit per key
    localparam int             KEY_N    = 20;
    localparam int             KEY_W    = 5;
    localparam logic [KEY_W-1:0] KEY_D9   = 5'h09;
    localparam logic [KEY_W-1:0] KEY_DOT  = 5'h0A;
    localparam logic [KEY_W-1:0] KEY_ADD  = 5'h0B;
    localparam logic [KEY_W-1:0] KEY_SUB  = 5'h0C;
    localparam logic [KEY_W-1:0] KEY_MUL  = 5'h0D;
    localparam logic [KEY_W-1:0] KEY_DIV  = 5'h0E;
    localparam logic [KEY_W-1:0] KEY_EQU  = 5'h0F;
    localparam logic [KEY_W-1:0] KEY_FUNC = 5'h10;
    localparam logic [KEY_W-1:0] KEY_CE   = 5'h11;
    localparam logic [KEY_W-1:0] KEY_AC   = 5'h12;
    localparam logic [KEY_W-1:0] KEY_OFF  = 5'h13;

    // Digit limits
    localparam int             DIG_W        = 5;
    localparam int             DP_W         = 4;
    localparam int             ENT_W        = 4;
    localparam logic [DIG_W-1:0] MAX_DIGITS   = 5'h08;
    localparam logic [DIG_W-1:0] ROUGH_DIGITS = 5'h10;
    localparam logic [ENT_W-1:0] MAX_ENTRY    = 4'h8;
    localparam logic [DP_W-1:0]  DP_NONE      = 4'h0;

    typedef enum logic [2:0] {
        KIND_ARITH, KIND_PCT, KIND_SQUARE, KIND_RECIP,
        KIND_POWER, KIND_MEMORY, KIND_MARKUP, KIND_SQRT
    } edc_kind_t;

    typedef enum logic [1:0] {ST_OFF, ST_READY, ST_SYS_ERR, ST_ROUGH_ERR} edc_state_t;

    typedef enum logic [1:0] {DB_IDLE, DB_PRESS, DB_HELD, DB_RELEASE} edc_db_state_t;

endpackage : edc_pkg

// [rtl/edc_debounce.sv]
`timescale 1ns/1ps
module edc_debounce
    import edc_pkg::*;
#(
    parameter int PRESS_N   = PRESS_WORDS,
    parameter int RELEASE_N = RELEASE_WORDS
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Word timing
    input  wire logic             word_tick,
    // Scanned key
    input  wire logic             raw_any,
    input  wire logic [KEY_W-1:0] raw_code,
    // Accepted key
    output logic                  press,
    output logic                  held,
    output logic [KEY_W-1:0]      code
);

    edc_db_state_t state;
    logic [3:0]    cnt;
    logic          press_done;
    logic          release_done;

    // Counting whole word ticks puts the accept delay between N-1 and N words
    assign press_done   = state == DB_PRESS && raw_any && raw_code == code && word_tick
                          && cnt == 4'(PRESS_N - 1);
    assign release_done = state == DB_RELEASE && !raw_any && word_tick
                          && cnt == 4'(RELEASE_N - 1);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= DB_IDLE;
            cnt   <= '0;
            code  <= '0;
        end
        else
        begin
            case (state)
                DB_IDLE:
                begin
                    if (raw_any)
                    begin
                        state <= DB_PRESS;
                        cnt   <= '0;
                        code  <= raw_code;
                    end
                end
                DB_PRESS:
                begin
                    // Any bounce or code change restarts the front edge wait
                    if (!raw_any || raw_code != code)
                        state <= DB_IDLE;
                    else if (press_done)
                        state <= DB_HELD;
                    else if (word_tick)
                        cnt <= cnt + 4'h1;
                end
                DB_HELD:
                begin
                    if (!raw_any)
                    begin
                        state <= DB_RELEASE;
                        cnt   <= '0;
                    end
                end
                DB_RELEASE:
                begin
                    if (raw_any)
                        state <= DB_HELD;
                    else if (release_done)
                        state <= DB_IDLE;
                    else if (word_tick)
                        cnt <= cnt + 4'h1;
                end
                default:
                    state <= DB_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            press <= 1'b0;
            held  <= 1'b0;
        end
        else
        begin
            press <= press_done;
            if (press_done)
                held <= 1'b1;
            else if (release_done)
                held <= 1'b0;
        end
    end

endmodule : edc_debounce

// [test/edc_keypad.sv]
`timescale 1ns/1ps
module edc_keypad
    import edc_pkg::*;
(
    // Clock
    input  wire logic             clk,
    // Keys the user holds down
    input  wire logic [KEY_N-1:0] hold,
    // Matrix lines into the chip
    output logic      [KEY_N-1:0] key_raw
);
    // Contacts close one cycle after the finger, never sooner
    always_ff @(posedge clk)
    begin
        key_raw <= hold;
    end
endmodule : edc_keypad

// [test/test_eight_digit_calculator_control.sv]
`timescale 1ns/1ps
module test_eight_digit_calculator_control;
    import edc_pkg::*;
    localparam int W   = 8;
    localparam int APO = 20;
    logic clk = 0, resetn = 0, res_valid = 0, res_div_zero = 0, res_sqrt_neg = 0;
    logic mem_store_req = 0, mem_nonzero = 0, got_dig, got_keep, got_clr, got_ce;
    logic [KEY_N-1:0] hold = '0, key_raw;
    edc_kind_t res_kind = KIND_ARITH;
    logic [DIG_W-1:0] res_int_digits = '0, mem_operand_digits = '0;
    logic [DP_W-1:0] res_dp_pos = '0, dp_pos;
    logic [KEY_W-1:0] key_code;
    logic [ENT_W-1:0] entry_count;
    logic key_accept, key_held, digit_accept, clear_all, clear_entry, keep_result;
    logic mem_write, power_on, sys_error, rough_error, err_sym, mem_sym, force_zero;
    logic zero_shift, lead_blank;
    int error_cnt = 0, n_compared = 0;
    always #10 clk = ~clk;
    edc_keypad edc_keypad_i (.clk(clk), .hold(hold), .key_raw(key_raw));
    edc_control #(.WORD_CYCLES(W), .APO_WORDS(APO)) edc_control_i (.clk(clk),
        .resetn(resetn), .key_raw(key_raw), .res_valid(res_valid), .res_kind(res_kind),
        .res_int_digits(res_int_digits), .res_dp_pos(res_dp_pos),
        .res_div_zero(res_div_zero), .res_sqrt_neg(res_sqrt_neg),
        .mem_operand_digits(mem_operand_digits), .mem_store_req(mem_store_req),
        .mem_nonzero(mem_nonzero), .key_accept(key_accept), .key_code(key_code),
        .key_held(key_held), .digit_accept(digit_accept), .entry_count(entry_count),
        .clear_all(clear_all), .clear_entry(clear_entry), .keep_result(keep_result),
        .mem_write(mem_write), .power_on(power_on), .sys_error(sys_error),
        .rough_error(rough_error), .err_sym(err_sym), .mem_sym(mem_sym),
        .force_zero(force_zero), .dp_pos(dp_pos), .zero_shift(zero_shift),
        .lead_blank(lead_blank));
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit
    task automatic chk_vec(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_vec
    task automatic report_and_stop;
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // Hold three words, release, then let the nine-word release run out
    task automatic press(input logic [KEY_N-1:0] m);
        int n;
        n = 0;
        @(posedge clk);
        hold <= m;
        while (key_accept !== 1'b1 && n < 3 * W + 8)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_bit("press_delay", 1'b1, n >= W + 4 && n <= 2 * W + 6);
        got_dig  = digit_accept;
        got_keep = keep_result;
        got_clr  = clear_all;
        got_ce   = clear_entry;
        cyc(3 * W - n);
        hold <= '0;
        cyc(7 * W);
        #1;
        chk_bit("held_in_release", 1'b1, key_held);
        cyc(3 * W + 2);
        #1;
        chk_bit("held_after_release", 1'b0, key_held);
    endtask : press
    task automatic t_digits;
        for (int i = 0; i < 9; i++)
        begin
            press(KEY_N'(1) << (i + 1));
            chk_bit("digit_accept", i < 8, got_dig);
        end
        chk_vec("entry_count", 8'(MAX_ENTRY), 8'(entry_count));
    endtask : t_digits
    // One result, judged the cycle after, then released by clear-entry
    task automatic result(input edc_kind_t k, input logic [4:0] d, md, input logic dz, sn,
                          input logic es, er);
        @(posedge clk);
        res_valid <= 1'b1;
        mem_store_req <= 1'b1;
        res_kind <= k;
        res_int_digits <= d;
        mem_operand_digits <= md;
        res_div_zero <= dz;
        res_sqrt_neg <= sn;
        res_dp_pos <= 4'h3;
        @(posedge clk);
        res_valid <= 1'b0;
        mem_store_req <= 1'b0;
        res_div_zero <= 1'b0;
        res_sqrt_neg <= 1'b0;
        #1;
        chk_bit("sys_error", es, sys_error);
        chk_bit("rough_error", er, rough_error);
        chk_bit("err_sym", es | er, err_sym);
        chk_bit("force_zero", es, force_zero);
        chk_bit("mem_write", !(es | er), mem_write);
        if (!(es | er))
        begin
            chk_vec("dp_pos", 8'h03, 8'(dp_pos));
            chk_bit("zero_shift", 1'b1, zero_shift);
        end
        if (er)
        begin
            chk_vec("dp_pos", 8'(16 - d), 8'(dp_pos));
            chk_bit("zero_shift", 1'b0, zero_shift);
        end
        press(KEY_N'(1) << KEY_CE);
        chk_bit("keep_result", er, got_keep);
        chk_bit("clear_entry", 1'b1, got_ce);
        chk_bit("sys_cleared", 1'b0, sys_error);
        chk_bit("rough_cleared", 1'b0, rough_error);
    endtask : result
    task automatic t_results;
        result(KIND_ARITH, 5'h08, 5'h00, 1'b0, 1'b0, 1'b0, 1'b0);
        result(KIND_ARITH, 5'h09, 5'h00, 1'b0, 1'b0, 1'b0, 1'b1);
        result(KIND_POWER, 5'h10, 5'h00, 1'b0, 1'b0, 1'b0, 1'b1);
        result(KIND_PCT, 5'h11, 5'h00, 1'b0, 1'b0, 1'b1, 1'b0);
        result(KIND_MARKUP, 5'h09, 5'h00, 1'b0, 1'b0, 1'b1, 1'b0);
        result(KIND_MEMORY, 5'h03, 5'h09, 1'b0, 1'b0, 1'b1, 1'b0);
        result(KIND_MEMORY, 5'h03, 5'h08, 1'b0, 1'b0, 1'b0, 1'b0);
        result(KIND_ARITH, 5'h01, 5'h00, 1'b1, 1'b0, 1'b1, 1'b0);
        result(KIND_SQRT, 5'h01, 5'h00, 1'b0, 1'b1, 1'b1, 1'b0);
    endtask : t_results
    task automatic t_off_priority;
        press((KEY_N'(1) << KEY_OFF) | (KEY_N'(1) << KEY_AC));
        chk_vec("key_code", 8'(KEY_OFF), 8'(key_code));
        chk_bit("power_on", 1'b0, power_on);
        press(KEY_N'(1) << KEY_CE);
        chk_bit("clear_all", 1'b1, got_clr);
        chk_bit("power_on", 1'b1, power_on);
        chk_bit("clear_entry", 1'b0, got_ce);
        press(KEY_N'(1) << KEY_AC);
        chk_bit("clear_all", 1'b1, got_clr);
        chk_bit("clear_entry", 1'b0, got_ce);
        chk_vec("entry_count", 8'h00, 8'(entry_count));
    endtask : t_off_priority
    task automatic t_mem_sym;
        @(posedge clk);
        mem_nonzero <= 1'b1;
        cyc(2);
        #1;
        chk_bit("mem_sym", 1'b1, mem_sym);
        @(posedge clk);
        mem_nonzero <= 1'b0;
        cyc(2);
        #1;
        chk_bit("mem_sym", 1'b0, mem_sym);
    endtask : t_mem_sym
    // Last accept lies some 11 words back when press returns
    task automatic t_auto_off;
        press(KEY_N'(1) << KEY_D9);
        cyc(6 * W);
        #1;
        chk_bit("power_on_idle", 1'b1, power_on);
        cyc(5 * W);
        #1;
        chk_bit("power_on_idle", 1'b0, power_on);
    endtask : t_auto_off
    initial
    begin
        cyc(8);
        resetn <= 1'b1;
        #1;
        chk_bit("lead_blank", 1'b1, lead_blank);
        chk_bit("power_on", 1'b1, power_on);
        t_digits();
        t_results();
        t_off_priority();
        t_mem_sym();
        t_auto_off();
        report_and_stop();
    end
    initial
    begin
        cyc(20000);
        error_cnt++;
        report_and_stop();
    end
endmodule : test_eight_digit_calculator_control
